// ### hw/mitmr_defs.svh
`ifndef MITMR_DEFS_SVH
`define MITMR_DEFS_SVH

// Printed register indices; byte address is four times the index
`define MITMR_IDX_RUN 32'hFFFF_83D0
`define MITMR_IDX_CSR0 32'hFFFF_83D2
`define MITMR_IDX_CNT0 32'hFFFF_83D4
`define MITMR_IDX_COR0 32'hFFFF_83D6
`define MITMR_IDX_CSR1 32'hFFFF_83D8
`define MITMR_IDX_CNT1 32'hFFFF_83DA
`define MITMR_IDX_COR1 32'hFFFF_83DC

// Register select positions
`define MITMR_SEL_RUN 0
`define MITMR_SEL_CSR0 1
`define MITMR_SEL_CNT0 2
`define MITMR_SEL_COR0 3
`define MITMR_SEL_CSR1 4
`define MITMR_SEL_CNT1 5
`define MITMR_SEL_COR1 6
`define MITMR_NUM_REGS 7

// Field positions
`define MITMR_CSR_FLAG_BIT 7
`define MITMR_CSR_IE_BIT 6
`define MITMR_CSR_CKS_HI 1
`define MITMR_CSR_CKS_LO 0

// Reset values
`define MITMR_RUN_RESET 2'h0
`define MITMR_CKS_RESET 2'h0
`define MITMR_CNT_RESET 16'h0000
`define MITMR_COR_RESET 16'hFFFF

// Prescaler: log2 of the four divisions
`define MITMR_PRE_WIDTH 9
`define MITMR_DIV_LOG2_0 3
`define MITMR_DIV_LOG2_1 5
`define MITMR_DIV_LOG2_2 7
`define MITMR_DIV_LOG2_3 9

`endif

// ### hw/mitmr_pkg.sv
`default_nettype none
`include "mitmr_defs.svh"

package mitmr_pkg;

  typedef logic [15:0] mitmr_word_t;

  typedef enum logic [1:0] {
    MITMR_OKAY = 2'b00,
    MITMR_SLVERR = 2'b10
  } mitmr_resp_t;

  typedef enum logic [1:0] {
    MITMR_WR_COLLECT = 2'b01,
    MITMR_WR_RESP = 2'b10
  } mitmr_wr_state_t;

  typedef enum logic [1:0] {
    MITMR_RD_IDLE = 2'b01,
    MITMR_RD_RESP = 2'b10
  } mitmr_rd_state_t;

  typedef logic [`MITMR_NUM_REGS-1:0] mitmr_sel_t;

  function automatic mitmr_sel_t mitmr_decode(input logic [31:0] addr);
    logic [31:0] idx [`MITMR_NUM_REGS];
    mitmr_sel_t sel;
    idx[`MITMR_SEL_RUN] = `MITMR_IDX_RUN;
    idx[`MITMR_SEL_CSR0] = `MITMR_IDX_CSR0;
    idx[`MITMR_SEL_CNT0] = `MITMR_IDX_CNT0;
    idx[`MITMR_SEL_COR0] = `MITMR_IDX_COR0;
    idx[`MITMR_SEL_CSR1] = `MITMR_IDX_CSR1;
    idx[`MITMR_SEL_CNT1] = `MITMR_IDX_CNT1;
    idx[`MITMR_SEL_COR1] = `MITMR_IDX_COR1;
    sel = '0;
    // Index wraps: only the low 30 index bits survive the times-four
    for (int i = 0; i < `MITMR_NUM_REGS; i++) begin
      sel[i] = (addr[31:2] == idx[i][29:0]);
    end
    return sel;
  endfunction

endpackage

`default_nettype wire

// ### hw/mitmr_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "mitmr_defs.svh"

module mitmr_channel #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic standby,
  // Shared timing
  input wire logic [3:0] ticks,
  input wire logic run,
  // Register access
  input wire logic csrWr,
  input wire logic cntWr,
  input wire logic corWr,
  input wire logic csrRead,
  input wire logic [CW-1:0] wrData,
  input wire logic [CW/8-1:0] wrStrb,
  // Channel state
  output logic [CW-1:0] count,
  output logic [CW-1:0] period,
  output logic matchFlag,
  output logic matchIrqEnable,
  output logic [1:0] prescaleSelect,
  output logic matchIrqRequest
);

  function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                          input logic [CW-1:0] nw,
                                          input logic [CW/8-1:0] strb);
    logic [CW-1:0] res;
    res = old;
    for (int b = 0; b < CW/8; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic readOne;
  logic tick;
  logic match;
  logic [CW-1:0] next_count;
  logic [CW-1:0] next_period;
  logic next_matchFlag;
  logic next_matchIrqEnable;
  logic [1:0] next_prescaleSelect;
  logic next_matchIrqRequest;
  logic next_readOne;

  always_comb begin
    tick = ticks[prescaleSelect];
    // Match is seen on the tick after equality, so the top value lasts a period
    match = run && tick && (count == period);
    next_count = count;
    next_period = period;
    next_matchFlag = matchFlag;
    next_matchIrqEnable = matchIrqEnable;
    next_prescaleSelect = prescaleSelect;
    next_readOne = readOne;
    if (corWr) begin
      next_period = merge(period, wrData, wrStrb);
    end
    if (match) begin
      next_count = '0;
    end else if (cntWr) begin
      // Any write, byte or word, swallows a coinciding increment
      next_count = merge(count, wrData, wrStrb);
    end else if (run && tick) begin
      next_count = count + CW'(1);
    end
    if (csrRead && matchFlag) begin
      next_readOne = 1'b1;
    end
    if (csrWr) begin
      next_readOne = 1'b0;
      if (wrStrb[0]) begin
        next_matchIrqEnable = wrData[`MITMR_CSR_IE_BIT];
        next_prescaleSelect = wrData[`MITMR_CSR_CKS_HI:`MITMR_CSR_CKS_LO];
        if (!wrData[`MITMR_CSR_FLAG_BIT] && readOne) begin
          next_matchFlag = 1'b0;
        end
      end
    end
    // Set after clear so a match in the clearing cycle is kept
    if (match) begin
      next_matchFlag = 1'b1;
    end
    if (standby) begin
      next_count = CW'(`MITMR_CNT_RESET);
      next_period = CW'(`MITMR_COR_RESET);
      next_matchFlag = 1'b0;
      next_matchIrqEnable = 1'b0;
      next_prescaleSelect = `MITMR_CKS_RESET;
      next_readOne = 1'b0;
    end
    next_matchIrqRequest = next_matchFlag && next_matchIrqEnable;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count <= CW'(`MITMR_CNT_RESET);
      period <= CW'(`MITMR_COR_RESET);
      matchFlag <= 1'b0;
      matchIrqEnable <= 1'b0;
      prescaleSelect <= `MITMR_CKS_RESET;
      matchIrqRequest <= 1'b0;
      readOne <= 1'b0;
    end else begin
      count <= next_count;
      period <= next_period;
      matchFlag <= next_matchFlag;
      matchIrqEnable <= next_matchIrqEnable;
      prescaleSelect <= next_prescaleSelect;
      matchIrqRequest <= next_matchIrqRequest;
      readOne <= next_readOne;
    end
  end

endmodule

`default_nettype wire

// ### hw/mitmr_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mitmr_defs.svh"

module mitmr_top #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Power state
  input wire logic standby,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output mitmr_pkg::mitmr_resp_t bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output mitmr_pkg::mitmr_resp_t rresp,
  // Interrupt requests, bit n for channel n
  output logic [1:0] matchIrqRequest
);
  import mitmr_pkg::*;

  localparam int DIV_LOG2 [4] = '{`MITMR_DIV_LOG2_0, `MITMR_DIV_LOG2_1,
                                  `MITMR_DIV_LOG2_2, `MITMR_DIV_LOG2_3};

  // Prescaler
  logic [`MITMR_PRE_WIDTH-1:0] prescale;
  logic [`MITMR_PRE_WIDTH-1:0] next_prescale;
  logic [3:0] ticks;

  always_comb begin
    next_prescale = prescale + `MITMR_PRE_WIDTH'(1);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prescale <= '0;
    end else begin
      prescale <= next_prescale;
    end
  end

  // Enable pulses keep everything on mclk, no gated clocks to balance
  for (genvar g = 0; g < 4; g++) begin : gen_tick
    assign ticks[g] = &prescale[DIV_LOG2[g]-1:0];
  end

  // Write path state
  mitmr_wr_state_t wrState;
  mitmr_wr_state_t next_wrState;
  logic awHeld;
  logic wHeld;
  logic [31:0] awAddrHeld;
  logic [15:0] wDataHeld;
  logic [1:0] wStrbHeld;
  logic next_awHeld;
  logic next_wHeld;
  logic [31:0] next_awAddrHeld;
  logic [15:0] next_wDataHeld;
  logic [1:0] next_wStrbHeld;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  mitmr_resp_t next_bresp;
  mitmr_sel_t wrSel;

  // Read path state
  mitmr_rd_state_t rdState;
  mitmr_rd_state_t next_rdState;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  mitmr_resp_t next_rresp;
  mitmr_sel_t rdSel;

  // Shared run control and channel views
  logic [1:0] run;
  logic [1:0] next_run;
  logic [1:0][CW-1:0] chCount;
  logic [1:0][CW-1:0] chPeriod;
  logic [1:0] chFlag;
  logic [1:0] chIrqEnable;
  logic [1:0][1:0] chSelect;
  logic [1:0] csrWr;
  logic [1:0] cntWr;
  logic [1:0] corWr;
  logic [1:0] csrRead;

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddrHeld = awAddrHeld;
    next_wDataHeld = wDataHeld;
    next_wStrbHeld = wStrbHeld;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_wrState = wrState;
    wrSel = '0;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddrHeld = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      // Registers are 16 bits: upper lanes are dropped
      next_wDataHeld = wdata[15:0];
      next_wStrbHeld = wstrb[1:0];
    end
    case (wrState)
      MITMR_WR_COLLECT: begin
        if (awHeld && wHeld) begin
          wrSel = mitmr_decode(awAddrHeld);
          next_bresp = (|wrSel) ? MITMR_OKAY : MITMR_SLVERR;
          next_bvalid = 1'b1;
          next_awHeld = 1'b0;
          next_wHeld = 1'b0;
          next_wrState = MITMR_WR_RESP;
        end
      end
      MITMR_WR_RESP: begin
        if (bready) begin
          next_bvalid = 1'b0;
          next_wrState = MITMR_WR_COLLECT;
        end
      end
      default: begin
        next_bvalid = 1'b0;
        next_wrState = MITMR_WR_COLLECT;
      end
    endcase
    next_awready = (next_wrState == MITMR_WR_COLLECT) && !next_awHeld;
    next_wready = (next_wrState == MITMR_WR_COLLECT) && !next_wHeld;
  end

  always_comb begin
    next_run = run;
    if (wrSel[`MITMR_SEL_RUN] && wStrbHeld[0]) begin
      next_run = wDataHeld[1:0];
    end
    if (standby) begin
      next_run = `MITMR_RUN_RESET;
    end
    csrWr[0] = wrSel[`MITMR_SEL_CSR0];
    csrWr[1] = wrSel[`MITMR_SEL_CSR1];
    cntWr[0] = wrSel[`MITMR_SEL_CNT0];
    cntWr[1] = wrSel[`MITMR_SEL_CNT1];
    corWr[0] = wrSel[`MITMR_SEL_COR0];
    corWr[1] = wrSel[`MITMR_SEL_COR1];
  end

  always_comb begin
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rdState = rdState;
    rdSel = '0;
    case (rdState)
      MITMR_RD_IDLE: begin
        if (arvalid && arready) begin
          rdSel = mitmr_decode(araddr);
          next_rdata = '0;
          for (int c = 0; c < 2; c++) begin
            if (rdSel[1 + 3*c]) begin
              // Reserved control bits read zero
              next_rdata[`MITMR_CSR_FLAG_BIT] = chFlag[c];
              next_rdata[`MITMR_CSR_IE_BIT] = chIrqEnable[c];
              next_rdata[`MITMR_CSR_CKS_HI:`MITMR_CSR_CKS_LO] = chSelect[c];
            end
            if (rdSel[2 + 3*c]) begin
              next_rdata[CW-1:0] = chCount[c];
            end
            if (rdSel[3 + 3*c]) begin
              next_rdata[CW-1:0] = chPeriod[c];
            end
          end
          if (rdSel[`MITMR_SEL_RUN]) begin
            next_rdata[1:0] = run;
          end
          next_rresp = (|rdSel) ? MITMR_OKAY : MITMR_SLVERR;
          next_rvalid = 1'b1;
          next_arready = 1'b0;
          next_rdState = MITMR_RD_RESP;
        end
      end
      MITMR_RD_RESP: begin
        if (rready) begin
          next_rvalid = 1'b0;
          next_arready = 1'b1;
          next_rdState = MITMR_RD_IDLE;
        end
      end
      default: begin
        next_rvalid = 1'b0;
        next_arready = 1'b1;
        next_rdState = MITMR_RD_IDLE;
      end
    endcase
    // Ready follows the state, so it also rises on the first cycle out of reset
    next_arready = (next_rdState == MITMR_RD_IDLE);
    csrRead[0] = rdSel[`MITMR_SEL_CSR0];
    csrRead[1] = rdSel[`MITMR_SEL_CSR1];
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrState <= MITMR_WR_COLLECT;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= '0;
      wDataHeld <= '0;
      wStrbHeld <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= MITMR_OKAY;
      rdState <= MITMR_RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= MITMR_OKAY;
      run <= `MITMR_RUN_RESET;
    end else begin
      wrState <= next_wrState;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddrHeld <= next_awAddrHeld;
      wDataHeld <= next_wDataHeld;
      wStrbHeld <= next_wStrbHeld;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rdState <= next_rdState;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      run <= next_run;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : gen_ch
    mitmr_channel #(
      .CW(CW)
    ) u_channel (
      .mclk(mclk),
      .resetn(resetn),
      .standby(standby),
      .ticks(ticks),
      .run(run[c]),
      .csrWr(csrWr[c]),
      .cntWr(cntWr[c]),
      .corWr(corWr[c]),
      .csrRead(csrRead[c]),
      .wrData(wDataHeld[CW-1:0]),
      .wrStrb(wStrbHeld[CW/8-1:0]),
      .count(chCount[c]),
      .period(chPeriod[c]),
      .matchFlag(chFlag[c]),
      .matchIrqEnable(chIrqEnable[c]),
      .prescaleSelect(chSelect[c]),
      .matchIrqRequest(matchIrqRequest[c])
    );
  end

endmodule

`default_nettype wire

// ### dv/mitmr_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "mitmr_defs.svh"

module mitmr_top_properties #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic standby,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // Interrupt requests
  input wire logic [1:0] matchIrqRequest
);
  import mitmr_pkg::*;
  localparam logic [31:0] A_RUN = `MITMR_IDX_RUN << 2;
  localparam logic [31:0] A_CSR0 = `MITMR_IDX_CSR0 << 2;
  localparam logic [31:0] A_CSR1 = `MITMR_IDX_CSR1 << 2;
  localparam logic [31:0] A_COR0 = `MITMR_IDX_COR0 << 2;
  logic [8:0] pre;
  logic [8:0] next_pre;
  logic [2:0] preLow;
  // Mirror of the divider; only resetn clears it
  always_comb begin
    next_pre = resetn ? pre + 9'h001 : 9'h000;
  end
  always_ff @(posedge mclk) begin
    pre <= next_pre;
  end
  assign preLow = pre[2:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence rdTake(logic [31:0] a);
    arvalid && arready && araddr == a;
  endsequence
  sequence wrTake;
    awvalid && awready && wvalid && wready;
  endsequence
  upper_half_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("Upper read half not zero");
  run_reserved_zero_a: assert property (rdTake(A_RUN) |=> rvalid && rdata[15:2] == 14'h0000)
    else $error("Run register reserved bits set");
  csr_reserved_zero_a: assert property ((rdTake(A_CSR0) or rdTake(A_CSR1)) |=>
    rvalid && rdata[15:8] == 8'h00 && rdata[5:2] == 4'h0)
    else $error("Control reserved bits set");
  standby_irq_low_a: assert property (standby [*3] |-> matchIrqRequest == 2'b00)
    else $error("Request high in standby");
  standby_period_a: assert property ((standby && $past(standby)) ##0 rdTake(A_COR0)
    |=> rdata[15:0] == 16'hFFFF)
    else $error("Constant not all ones in standby");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("Read answer late");
  write_answer_a: assert property (wrTake |=> ##[0:1] bvalid)
    else $error("Write answer late");
  irq_clear_write_a: assert property (($fell(matchIrqRequest[0]) ||
    $fell(matchIrqRequest[1])) && !$past(standby) && !$past(standby, 2)
    |-> bvalid || $past(bvalid))
    else $error("Request dropped without a write");
  irq_on_tick_a: assert property (($rose(matchIrqRequest[0]) ||
    $rose(matchIrqRequest[1])) |-> $past(preLow) == 3'h7 || $past(preLow, 2) == 3'h7)
    else $error("Request rose off a count tick");
endmodule

bind mitmr_top mitmr_top_properties #(.CW(CW)) props (
  .mclk, .resetn, .standby, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .arvalid, .arready, .araddr, .rvalid, .rdata, .matchIrqRequest
);

`default_nettype wire

// ### dv/mitmr_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mitmr_defs.svh"

module mitmr_tb_top;
  import mitmr_pkg::*;
  localparam logic [31:0] A [7] = '{`MITMR_IDX_RUN << 2, `MITMR_IDX_CSR0 << 2,
    `MITMR_IDX_CNT0 << 2, `MITMR_IDX_COR0 << 2, `MITMR_IDX_CSR1 << 2,
    `MITMR_IDX_CNT1 << 2, `MITMR_IDX_COR1 << 2};
  logic mclk = 1'b0, resetn = 1'b0, standby = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, araddr = 32'h0000_0000, wdata = 32'h0000_0000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] irq;
  mitmr_resp_t bresp, rresp;
  int nErrors = 0, compares = 0, cyc = 0;
  int mdl [7] = '{0, 0, 0, 65535, 0, 0, 65535};

  mitmr_top #(
    .CW(16)
  ) DUT (
    .mclk, .resetn, .standby, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .matchIrqRequest(irq)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s,
                    output mitmr_resp_t r);
    int n;
    n = 0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    awprot <= 3'($urandom_range(7));
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    r = bresp;
    bready <= 1'b0;
    check(32'(n < 100), 32'h1);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output mitmr_resp_t r);
    int n;
    n = 0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    arprot <= 3'($urandom_range(7));
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check(32'(n < 100), 32'h1);
  endtask

  task automatic wrc(input logic [31:0] a, input logic [15:0] d);
    mitmr_resp_t r;
    wr(a, d, 4'h3, r);
    check({30'h0, r}, {30'h0, MITMR_OKAY});
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    mitmr_resp_t r;
    rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, MITMR_OKAY});
  endtask

  task automatic chkAll();
    for (int i = 0; i < 7; i++) rdc(A[i], mdl[i]);
  endtask

  // Cycle stamp taken at the first edge that sees the request high
  task automatic waitIrq(input int ch, output int t);
    int n;
    n = 0;
    while (irq[ch] !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    t = cyc;
    check(32'(n < 20000), 32'h1);
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    nErrors++;
    $display("Error at %0t: run timed out", $time);
    end_sim();
  end

  initial begin
    int cor, t1, t2, ch, div, c;
    logic [31:0] d1, d2;
    mitmr_resp_t r;
    void'($urandom(92));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    chkAll();
    // Holes in the map answer with an error and no data
    rd(A[0] + 32'h0000_0004, d1, r);
    check(d1, 32'h0000_0000);
    check({30'h0, r}, {30'h0, MITMR_SLVERR});
    wr(A[0] - 32'h0000_0004, 16'hFFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, MITMR_SLVERR});
    wr(A[3], 16'h00AB, 4'h1, r);
    rdc(A[3], 32'h0000_FFAB);
    wr(A[3], 16'h1200, 4'h2, r);
    rdc(A[3], 32'h0000_12AB);
    wrc(A[0], 16'h0003);
    rdc(A[0], 32'h0000_0003);
    wrc(A[1], 16'h00C3);
    rdc(A[1], 32'h0000_0043);
    wrc(A[1], 16'h0000);
    wrc(A[0], 16'h0002);
    wrc(A[2], 16'h1234);
    rd(A[5], d1, r);
    repeat (64) @(posedge mclk);
    rdc(A[2], 32'h0000_1234);
    rd(A[5], d2, r);
    check(32'(d2 > d1), 32'h1);
    // Period measured between two rises, so the request latency cancels out
    for (int k = 0; k < 4; k++) begin
      ch = k % 2;
      div = 8 << (2 * k);
      cor = 3 + $urandom_range(2);
      c = 1 + 3 * ch;
      wrc(A[0], 16'h0000);
      wrc(A[c + 1], 16'h0000);
      wrc(A[c + 2], 16'(cor));
      wrc(A[c], 16'(8'h40 | k));
      wrc(A[5 - c], 16'h0040);
      wrc(A[0], 16'(1 << ch));
      waitIrq(ch, t1);
      check({31'h0, irq[1 - ch]}, 32'h0);
      wrc(A[c], 16'(8'h40 | k));
      repeat (2) @(posedge mclk);
      check({31'h0, irq[ch]}, 32'h1);
      rdc(A[c], 32'(8'hC0 | k));
      wrc(A[c], 16'(8'h40 | k));
      repeat (2) @(posedge mclk);
      check({31'h0, irq[ch]}, 32'h0);
      waitIrq(ch, t2);
      check(32'(t2 - t1), 32'((cor + 1) * div));
      wrc(A[0], 16'h0000);
      rdc(A[c], 32'(8'hC0 | k));
      wrc(A[c], 16'h0000);
    end
    wrc(A[0], 16'h0003);
    wrc(A[4], 16'h0041);
    standby <= 1'b1;
    chkAll();
    standby <= 1'b0;
    end_sim();
  end
endmodule

`default_nettype wire
